// ===== fst_defines.svh
/*
  constants of the frame-synchronous transfer utility: register map, field
  positions, command codes and timing figures.
  assumes: included by its bare name from every design file that needs it.
*/
`ifndef FST_DEFINES_SVH
`define FST_DEFINES_SVH

`define FST_A_DATA_A 4'h0
`define FST_A_RX_A 4'h2
`define FST_A_TX_A 4'h4
`define FST_A_CTRL 4'h6
`define FST_A_IRQ 4'h7
`define FST_A_STAT 4'h8
`define FST_A_MDATA 4'h9
`define FST_A_MADDR 4'hA
`define FST_A_MCMD 4'hB

`define FST_IFSEL 7
`define FST_SLOT 6:0
`define FST_EN_A 6
`define FST_EN_B 7
`define FST_TYPE_A 0
`define FST_TYPE_B 3
`define FST_IRQ_SIN 1
`define FST_IRQ_SOV 0
`define FST_ST_BUSY 7
`define FST_ST_WIN 0

`define FST_CMD_RD 7
`define FST_MOC_F 6:4
`define FST_MOC_CODE 3'h7
`define FST_MOC_DSEL 6:0
`define FST_MOC_DATA 7'h48
`define FST_CODE_F 3:0
`define FST_FLD_DATA 2'h1
`define FST_FLD_CODE 2'h2
`define FST_FLD_BOTH 2'h3

`define FST_CLK_MHZ 200
`define FST_FRAME_US 125
`define FST_RCL_KHZ 4096
`define FST_SLOT_RCL 16
`define FST_EXTRA_RCL 1

`endif

// ===== fst_pkg.sv
/*
  types of the frame-synchronous transfer utility.
  assumes: nothing beyond a SystemVerilog compiler.
*/
package fst_pkg;

  // sequencer: open window, per-channel write/read, closed hold, command unit
  typedef enum logic [2:0] {
    st_open, st_txw, st_rxr, st_rxw, st_rxc, st_hold, st_maw, st_mac
  } fst_state_t;

endpackage : fst_pkg

// ===== fst_tick_if.sv
/*
  frame and receive-clock timing strobes between the timer and the engine.
  assumes: both ends on ref_clk_i.
*/
`timescale 1ns/1ps

interface fst_tick_if;
  logic frame_start;
  logic rcl_tick;
  modport src (output frame_start, output rcl_tick);
  modport snk (input frame_start, input rcl_tick);
endinterface : fst_tick_if

// ===== fst_rcl_timer.sv
/*
  frame timer: one-cycle frame start every FRAME_CYC clocks and a
  receive-clock enable every RCL_DIV clocks, realigned at each frame.
  assumes: synchronous active-high reset, one clock.
*/
`timescale 1ns/1ps

module fst_rcl_timer #(
  parameter int FRAME_CYC = 25000,
  parameter int RCL_DIV = 48
)
(
  input wire logic ref_clk_i,
  input wire logic reset_i,
  fst_tick_if.src tk
);
  localparam int FW = $clog2(FRAME_CYC);
  localparam int DW = $clog2(RCL_DIV) + 1;

  logic [FW-1:0] fcnt_q;
  logic [DW-1:0] dcnt_q;
  logic fs_q;
  logic rt_q;
  wire f_end = fcnt_q == FW'(FRAME_CYC - 1);
  wire d_end = dcnt_q == DW'(RCL_DIV - 1);

  // strobes sit at fixed frame points, whatever the slot positions
  always_ff @(posedge ref_clk_i)
  begin
    if (reset_i)
    begin
      fcnt_q <= '0;
      dcnt_q <= '0;
      fs_q <= 1'b0;
      rt_q <= 1'b0;
    end
    else
    begin
      fcnt_q <= f_end ? '0 : fcnt_q + FW'(1);
      dcnt_q <= (f_end || d_end) ? '0 : dcnt_q + DW'(1);
      fs_q <= f_end;
      rt_q <= d_end;
    end
  end

  assign tk.frame_start = fs_q;
  assign tk.rcl_tick = rt_q;
endmodule : fst_rcl_timer

// ===== fst_subslot.sv
/*
  sub-slot mask: which bits of a time slot a channel exchanges.
  assumes: configurable-interface slots are always exchanged whole.
*/
`timescale 1ns/1ps

module fst_subslot (
  input wire logic [2:0] type_i,
  input wire logic cfi_i,
  output logic [7:0] mask_o
);
  // the configurable side has no sub-slots, so it always takes all bits
  always_comb
  begin
    mask_o = 8'h00;
    if (cfi_i)
      mask_o = 8'hFF;
    else
      unique case (type_i)
        3'h0: mask_o = 8'h00;
        3'h1: mask_o = 8'hFF;
        3'h2: mask_o = 8'h0F;
        3'h3: mask_o = 8'hF0;
        3'h4: mask_o = 8'h03;
        3'h5: mask_o = 8'h0C;
        3'h6: mask_o = 8'h30;
        3'h7: mask_o = 8'hC0;
      endcase
  end
endmodule : fst_subslot

// ===== fst_top.sv
/*
  fst_top: two-channel frame-synchronous transfer engine, its register file
  and the memory-access command unit for processor channels.
  assumes: one 200 MHz clock; synchronous reset; register bus and memory port
  on that clock; mem_rdata_i valid in the cycle after mem_req_o is high.
*/
`timescale 1ns/1ps
`include "fst_defines.svh"

module fst_top
  import fst_pkg::*;
#(
  parameter int FRAME_CYC = `FST_FRAME_US * `FST_CLK_MHZ,
  parameter int RCL_DIV = (`FST_CLK_MHZ * 1000) / `FST_RCL_KHZ
)
(
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic [3:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  output logic window_open_o,
  output logic mem_req_o,
  output logic mem_we_o,
  output logic mem_cm_o,
  output logic [1:0] mem_fld_o,
  output logic [7:0] mem_addr_o,
  output logic [7:0] mem_wdata_o,
  output logic [7:0] mem_wmask_o,
  output logic [3:0] mem_wcode_o,
  input wire logic [7:0] mem_rdata_i
);
  localparam int NCH = 2;
  localparam int CLOSE_MAX = (`FST_EXTRA_RCL + NCH * `FST_SLOT_RCL) * RCL_DIV;

  if (RCL_DIV < 2 || FRAME_CYC < 2 * CLOSE_MAX)
  begin : g_bad_cfg
    $error("fst_top: frame too short for the closed window");
  end

  fst_tick_if tk ();

  fst_rcl_timer #(
    .FRAME_CYC(FRAME_CYC),
    .RCL_DIV(RCL_DIV)
  ) u_timer (
    .ref_clk_i(ref_clk_i),
    .reset_i(reset_i),
    .tk(tk)
  );

  fst_state_t state_q, state_d;
  logic [7:0] data_q [NCH];
  logic [7:0] rxa_q [NCH];
  logic [7:0] txa_q [NCH];
  logic [7:0] ctrl_q;
  logic [1:0] irq_q;
  logic win_q;
  logic ch_q, ch_d;
  logic [NCH-1:0] en_lat_q, en_lat_d;
  logic [NCH-1:0] pend_q;
  logic fs_pend_q;
  logic [5:0] rcl_cnt_q;
  logic busy_q;
  logic [7:0] ma_data_q;
  logic [7:0] ma_addr_q;
  logic [7:0] ma_cmd_q;
  logic [7:0] rdata_q;
  logic mreq_q, mwe_q, mcm_q;
  logic [1:0] mfld_q;
  logic [7:0] maddr_q, mwd_q, mmask_q;
  logic [3:0] mcode_q;
  logic mreq_d, mwe_d, mcm_d;
  logic [1:0] mfld_d;
  logic [7:0] maddr_d, mwd_d, mmask_d;
  logic [3:0] mcode_d;

  // control register fields
  logic [NCH-1:0] en, wr_dat, rd_dat, cap;
  logic [2:0] ctype [NCH];
  assign en[0] = ctrl_q[`FST_EN_A];
  assign en[1] = ctrl_q[`FST_EN_B];
  assign ctype[0] = ctrl_q[`FST_TYPE_A +: 3];
  assign ctype[1] = ctrl_q[`FST_TYPE_B +: 3];

  // sub-slot masks for the slot being written and the slot being read
  logic [7:0] tmask, rmask;
  fst_subslot u_tmask (
    .type_i(ctype[ch_q]),
    .cfi_i(txa_q[ch_q][`FST_IFSEL]),
    .mask_o(tmask)
  );
  fst_subslot u_rmask (
    .type_i(ctype[ch_q]),
    .cfi_i(rxa_q[ch_q][`FST_IFSEL]),
    .mask_o(rmask)
  );

  // frame events and hold target
  wire fs_any = tk.frame_start || fs_pend_q;
  wire go_close = state_q == st_open && fs_any && |en;
  wire [NCH-1:0] pend_now = pend_q & ~(wr_dat | rd_dat);
  wire sov_evt = go_close && |(pend_now & en);
  wire [5:0] close_tgt = 6'(`FST_EXTRA_RCL + `FST_SLOT_RCL *
    (int'(en_lat_q[0]) + int'(en_lat_q[1])));
  // reopen on the edge that counts the last tick, so the closed spell never runs past it
  wire [5:0] rcl_next = rcl_cnt_q + 6'(tk.rcl_tick);
  wire hold_done = state_q == st_hold && rcl_next >= close_tgt;
  wire open_evt = hold_done;
  wire ma_go = state_q == st_open && busy_q && !fs_any;
  wire rd_irq = rd_i && addr_i == `FST_A_IRQ;

  // command decode; anything but a code-field or data-field access is dropped
  wire ma_rd = ma_cmd_q[`FST_CMD_RD];
  wire ma_code = ma_cmd_q[`FST_MOC_F] == `FST_MOC_CODE;
  wire cmd_ok = wdata_i[`FST_MOC_F] == `FST_MOC_CODE ||
    wdata_i[`FST_MOC_DSEL] == `FST_MOC_DATA;
  wire cmd_wr = wr_i && addr_i == `FST_A_MCMD && !busy_q && cmd_ok;

  // per-channel data and address registers
  for (genvar g = 0; g < NCH; g++)
  begin : g_ch
    // data registers only count as accessed while the window is open
    assign wr_dat[g] = wr_i && win_q && addr_i == `FST_A_DATA_A + 4'(g);
    assign rd_dat[g] = rd_i && win_q && addr_i == `FST_A_DATA_A + 4'(g);
    assign cap[g] = state_q == st_rxc && ch_q == 1'(g);

    // bit 7 is the serial bit first on the line unwritten value is resent
    always_ff @(posedge ref_clk_i)
    begin
      if (reset_i)
        data_q[g] <= 8'h00;
      else if (cap[g])
        data_q[g] <= (data_q[g] & ~rmask) | (mem_rdata_i & rmask);
      else if (wr_dat[g])
        data_q[g] <= wdata_i;
    end

    always_ff @(posedge ref_clk_i)
    begin
      if (reset_i)
      begin
        rxa_q[g] <= 8'h00;
        txa_q[g] <= 8'h00;
      end
      else if (wr_i && addr_i == `FST_A_RX_A + 4'(g))
        rxa_q[g] <= wdata_i;
      else if (wr_i && addr_i == `FST_A_TX_A + 4'(g))
        txa_q[g] <= wdata_i;
    end
  end

  // sequencer: close, write then read each enabled channel, hold, reopen
  always_comb
  begin
    state_d = state_q;
    ch_d = ch_q;
    en_lat_d = en_lat_q;
    unique case (state_q)
      st_open:
        if (go_close)
        begin
          state_d = st_txw;
          en_lat_d = en;
          ch_d = !en[0];
        end
        else if (ma_go)
          state_d = st_maw;
      st_txw: state_d = st_rxr;
      st_rxr: state_d = st_rxw;
      st_rxw: state_d = st_rxc;
      st_rxc:
        if (!ch_q && en_lat_q[1])
        begin
          ch_d = 1'b1;
          state_d = st_txw;
        end
        else
          state_d = st_hold;
      st_hold:
        if (hold_done)
          state_d = st_open;
      st_maw: state_d = st_mac;
      st_mac: state_d = st_open;
    endcase
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (reset_i)
    begin
      state_q <= st_open;
      ch_q <= 1'b0;
      en_lat_q <= '0;
    end
    else
    begin
      state_q <= state_d;
      ch_q <= ch_d;
      en_lat_q <= en_lat_d;
    end
  end

  // memory request; a write replaces the masked bits of whatever idle value sat there
  always_comb
  begin
    mreq_d = 1'b0;
    mwe_d = 1'b0;
    mcm_d = 1'b0;
    mfld_d = `FST_FLD_DATA;
    maddr_d = 8'h00;
    mwd_d = 8'h00;
    mmask_d = 8'h00;
    mcode_d = 4'h0;
    if (state_q == st_txw)
    begin
      mreq_d = 1'b1;
      mwe_d = 1'b1;
      mcm_d = txa_q[ch_q][`FST_IFSEL];
      maddr_d = {1'b0, txa_q[ch_q][`FST_SLOT]};
      mwd_d = data_q[ch_q];
      mmask_d = tmask;
    end
    else if (state_q == st_rxr)
    begin
      mreq_d = 1'b1;
      mcm_d = rxa_q[ch_q][`FST_IFSEL];
      maddr_d = {1'b0, rxa_q[ch_q][`FST_SLOT]};
      mmask_d = rmask;
    end
    else if (ma_go)
    begin
      // a code write stores code and data together in one access
      mreq_d = 1'b1;
      mwe_d = !ma_rd;
      mcm_d = 1'b1;
      mfld_d = ma_code ? (ma_rd ? `FST_FLD_CODE : `FST_FLD_BOTH) : `FST_FLD_DATA;
      maddr_d = ma_addr_q;
      mwd_d = ma_data_q;
      mmask_d = 8'hFF;
      mcode_d = ma_cmd_q[`FST_CODE_F];
    end
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (reset_i)
    begin
      {mreq_q, mwe_q, mcm_q, mfld_q} <= '0;
      {maddr_q, mwd_q, mmask_q, mcode_q} <= '0;
    end
    else
    begin
      {mreq_q, mwe_q, mcm_q, mfld_q} <= {mreq_d, mwe_d, mcm_d, mfld_d};
      {maddr_q, mwd_q, mmask_q, mcode_q} <= {maddr_d, mwd_d, mmask_d, mcode_d};
    end
  end

  // window, overrun arming, frame-start catch and closed-time count
  always_ff @(posedge ref_clk_i)
  begin
    if (reset_i)
    begin
      win_q <= 1'b1;
      pend_q <= '0;
      fs_pend_q <= 1'b0;
      rcl_cnt_q <= 6'h00;
    end
    else
    begin
      win_q <= go_close ? 1'b0 : (open_evt ? 1'b1 : win_q);
      pend_q <= open_evt ? en_lat_q : (go_close ? '0 : pend_now);
      fs_pend_q <= state_q != st_open && (fs_pend_q || tk.frame_start);
      if (go_close)
        rcl_cnt_q <= 6'h00;
      else if (tk.rcl_tick && rcl_cnt_q != 6'h3F)
        rcl_cnt_q <= rcl_cnt_q + 6'h01;
    end
  end

  // status flags: an event in the clearing read's cycle survives it
  always_ff @(posedge ref_clk_i)
  begin
    if (reset_i)
      irq_q <= 2'h0;
    else
    begin
      irq_q[`FST_IRQ_SIN] <= open_evt || (irq_q[`FST_IRQ_SIN] && !rd_irq);
      irq_q[`FST_IRQ_SOV] <= sov_evt || (irq_q[`FST_IRQ_SOV] && !rd_irq);
    end
  end

  // control register
  always_ff @(posedge ref_clk_i)
  begin
    if (reset_i)
      ctrl_q <= 8'h00;
    else if (wr_i && addr_i == `FST_A_CTRL)
      ctrl_q <= wdata_i;
  end

  // command unit; parameter registers are frozen while a command is busy
  always_ff @(posedge ref_clk_i)
  begin
    if (reset_i)
    begin
      busy_q <= 1'b0;
      ma_cmd_q <= 8'h00;
      ma_addr_q <= 8'h00;
    end
    else
    begin
      busy_q <= cmd_wr || (busy_q && state_q != st_mac);
      if (cmd_wr)
        ma_cmd_q <= wdata_i;
      if (wr_i && addr_i == `FST_A_MADDR && !busy_q)
        ma_addr_q <= wdata_i;
    end
  end

  // command data: code read lands in the low nibble; no status event
  always_ff @(posedge ref_clk_i)
  begin
    if (reset_i)
      ma_data_q <= 8'h00;
    else if (state_q == st_mac && ma_rd)
      ma_data_q <= ma_code ? {4'h0, mem_rdata_i[`FST_CODE_F]} : mem_rdata_i;
    else if (wr_i && addr_i == `FST_A_MDATA && !busy_q)
      ma_data_q <= wdata_i;
  end

  // read selection; unmapped addresses read zero
  wire [7:0] stat_v = ({7'h00, busy_q} << `FST_ST_BUSY) | ({7'h00, win_q} << `FST_ST_WIN);
  wire [7:0] rd_mux =
    addr_i == `FST_A_DATA_A ? data_q[0] :
    addr_i == `FST_A_DATA_A + 4'h1 ? data_q[1] :
    addr_i == `FST_A_RX_A ? rxa_q[0] :
    addr_i == `FST_A_RX_A + 4'h1 ? rxa_q[1] :
    addr_i == `FST_A_TX_A ? txa_q[0] :
    addr_i == `FST_A_TX_A + 4'h1 ? txa_q[1] :
    addr_i == `FST_A_CTRL ? ctrl_q :
    addr_i == `FST_A_IRQ ? {6'h00, irq_q} :
    addr_i == `FST_A_STAT ? stat_v :
    addr_i == `FST_A_MDATA ? ma_data_q :
    addr_i == `FST_A_MADDR ? ma_addr_q :
    addr_i == `FST_A_MCMD ? ma_cmd_q : 8'h00;

  // read data stands only in the cycle after the strobe
  always_ff @(posedge ref_clk_i)
  begin
    if (reset_i)
      rdata_q <= 8'h00;
    else
      rdata_q <= rd_i ? rd_mux : 8'h00;
  end

  assign rdata_o = rdata_q;
  assign window_open_o = win_q;
  assign mem_req_o = mreq_q;
  assign mem_we_o = mwe_q;
  assign mem_cm_o = mcm_q;
  assign mem_fld_o = mfld_q;
  assign mem_addr_o = maddr_q;
  assign mem_wdata_o = mwd_q;
  assign mem_wmask_o = mmask_q;
  assign mem_wcode_o = mcode_q;

  // helper counters watched only by the checks below
  logic [31:0] cl_cnt_q;
  logic [31:0] fr_cnt_q;
  logic fr_seen_q;
  always_ff @(posedge ref_clk_i)
  begin
    if (reset_i)
    begin
      cl_cnt_q <= 32'h0000_0000;
      fr_cnt_q <= 32'h0000_0000;
      fr_seen_q <= 1'b0;
    end
    else
    begin
      cl_cnt_q <= win_q ? 32'h0000_0000 : cl_cnt_q + 32'h0000_0001;
      fr_cnt_q <= tk.frame_start ? 32'h0000_0000 : fr_cnt_q + 32'h0000_0001;
      fr_seen_q <= fr_seen_q || tk.frame_start;
    end
  end

  property p_sov_first;
    @(posedge ref_clk_i) disable iff (reset_i)
      go_close && |(pend_now & en) |=> irq_q[`FST_IRQ_SOV] && !mem_req_o;
  endproperty
  a_sov_first: assert property (p_sov_first)
    else $error("overrun not flagged ahead of the transfers");

  property p_closed_len;
    @(posedge ref_clk_i) disable iff (reset_i)
      !win_q |-> cl_cnt_q < 32'(CLOSE_MAX);
  endproperty
  a_closed_len: assert property (p_closed_len)
    else $error("access window closed too long");

  property p_sin_needs_en;
    @(posedge ref_clk_i) disable iff (reset_i)
      $rose(irq_q[`FST_IRQ_SIN]) |-> |en_lat_q && $rose(win_q);
  endproperty
  a_sin_needs_en: assert property (p_sin_needs_en)
    else $error("window-open flag without an enabled channel or opening");

  property p_irq_clear;
    @(posedge ref_clk_i) disable iff (reset_i)
      rd_irq && !open_evt && !sov_evt |=> irq_q == 2'h0;
  endproperty
  a_irq_clear: assert property (p_irq_clear)
    else $error("status read did not clear the flags");

  property p_frame_period;
    @(posedge ref_clk_i) disable iff (reset_i)
      tk.frame_start && fr_seen_q |-> fr_cnt_q == 32'(FRAME_CYC - 1);
  endproperty
  a_frame_period: assert property (p_frame_period)
    else $error("frame period wrong");

  property p_data_cause;
    @(posedge ref_clk_i) disable iff (reset_i)
      ##1 $changed(data_q[0]) |-> $past(wr_dat[0]) || $past(cap[0]);
  endproperty
  a_data_cause: assert property (p_data_cause)
    else $error("data register changed without a cause");

  property p_closed_no_write;
    @(posedge ref_clk_i) disable iff (reset_i)
      !win_q && wr_i && addr_i == `FST_A_DATA_A && state_q == st_hold |=> $stable(data_q[0]);
  endproperty
  a_closed_no_write: assert property (p_closed_no_write)
    else $error("data register written while window closed");

  property p_only_enabled;
    @(posedge ref_clk_i) disable iff (reset_i)
      state_q == st_txw |-> en_lat_q[ch_q] ##1 mem_req_o && mem_we_o;
  endproperty
  a_only_enabled: assert property (p_only_enabled)
    else $error("transfer for a disabled channel");

  property p_write_then_read;
    @(posedge ref_clk_i) disable iff (reset_i)
      state_q == st_txw |-> ##2 mem_req_o && !mem_we_o ##1 state_q == st_rxc;
  endproperty
  a_write_then_read: assert property (p_write_then_read)
    else $error("write-then-read order broken");
endmodule : fst_top

// ===== fst_mem_model.sv
/*
  memory model: data memory and control memory behind the engine's port.
  assumes: one request per cycle on ref_clk_i, answer in the following cycle.
*/
`timescale 1ns/1ps

module fst_mem_model (
  input wire logic clk_i,
  input wire logic req_i,
  input wire logic we_i,
  input wire logic cm_i,
  input wire logic [1:0] fld_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic [7:0] wmask_i,
  input wire logic [3:0] wcode_i,
  output logic [7:0] rdata_o
);
  logic [7:0] dm [256];
  logic [7:0] cmdat [256];
  logic [3:0] cmc [256];

  // the engine is the only writer; a write replaces the wmask_i bits of any idle value there, a both-field write all of it
  always @(posedge clk_i)
  begin
    if (req_i && we_i && !cm_i)
      dm[addr_i] <= (dm[addr_i] & ~wmask_i) | (wdata_i & wmask_i);
    if (req_i && we_i && cm_i && fld_i == 2'h3)
      cmdat[addr_i] <= wdata_i;
    else if (req_i && we_i && cm_i && fld_i[0])
      cmdat[addr_i] <= (cmdat[addr_i] & ~wmask_i) | (wdata_i & wmask_i);
    if (req_i && we_i && cm_i && fld_i[1])
      cmc[addr_i] <= wcode_i;
  end

  // answer stands one cycle; otherwise the line wanders so stale data is caught
  initial rdata_o = 8'h5A;
  always @(posedge clk_i)
  begin
    if (req_i && !we_i)
      rdata_o <= !cm_i ? dm[addr_i] : (fld_i == 2'h2 ? {4'h0, cmc[addr_i]} : cmdat[addr_i]);
    else
      rdata_o <= ~rdata_o;
  end
endmodule : fst_mem_model

// ===== frame_sync_transfer_utility_test.sv
/*
  testbench: register-bus sequences against the transfer engine and its memory.
  assumes: shortened frame (2000 cycles, 8 cycles per receive-clock tick).
*/
`timescale 1ns/1ps
`include "fst_defines.svh"

module frame_sync_transfer_utility_test;
  localparam int FRAME = 2000;
  logic ref_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic [3:0] addr_i = 4'h0;
  logic [7:0] wdata_i = 8'h00;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [7:0] rdata_o;
  logic window_open_o;
  logic mem_req_o;
  logic mem_we_o;
  logic mem_cm_o;
  logic [1:0] mem_fld_o;
  logic [7:0] mem_addr_o;
  logic [7:0] mem_wdata_o;
  logic [7:0] mem_wmask_o;
  logic [3:0] mem_wcode_o;
  logic [7:0] mem_rdata_i;
  logic [7:0] rv;
  int n_fail = 0;
  int tests_run = 0;
  int cyc = 0;
  int t_close = 0;
  int per = 0;
  int n_req = 0;
  int n_shut = 0;
  int n0 = 0;
  int s0 = 0;

  initial forever #2.5 ref_clk_i = ~ref_clk_i;

  fst_top #(.FRAME_CYC(FRAME), .RCL_DIV(8)) i_dut (.ref_clk_i(ref_clk_i), .reset_i(reset_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .window_open_o(window_open_o), .mem_req_o(mem_req_o), .mem_we_o(mem_we_o),
    .mem_cm_o(mem_cm_o), .mem_fld_o(mem_fld_o), .mem_addr_o(mem_addr_o),
    .mem_wdata_o(mem_wdata_o), .mem_wmask_o(mem_wmask_o), .mem_wcode_o(mem_wcode_o),
    .mem_rdata_i(mem_rdata_i));

  fst_mem_model i_mem (.clk_i(ref_clk_i), .req_i(mem_req_o), .we_i(mem_we_o),
    .cm_i(mem_cm_o), .fld_i(mem_fld_o), .addr_i(mem_addr_o), .wdata_i(mem_wdata_o),
    .wmask_i(mem_wmask_o), .wcode_i(mem_wcode_o), .rdata_o(mem_rdata_i));

  // cycle count, request and closed-window tallies, hang limit
  always @(posedge ref_clk_i)
  begin
    cyc <= cyc + 1;
    if (mem_req_o === 1'b1)
      n_req <= n_req + 1;
    if (window_open_o === 1'b0)
      n_shut <= n_shut + 1;
    if (cyc == 30000)
    begin
      n_fail++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    if (n_fail == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : tally_and_finish

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp)
    begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic tick();
    @(posedge ref_clk_i);
    #1;
  endtask : tick

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge ref_clk_i);
    wr_i <= 1'b0;
  endtask : wr

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge ref_clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge ref_clk_i);
    rd_i <= 1'b0;
    #1;
    d = rdata_o;
  endtask : rd

  task automatic rd_chk(input string what, input logic [3:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd(a, d);
    chk(what, exp, d);
  endtask : rd_chk

  // issue a command and poll busy under a bound
  task automatic cmd(input logic [7:0] c);
    logic [7:0] s;
    wr(`FST_A_MCMD, c);
    for (int i = 0; i < 20; i++)
    begin
      rd(`FST_A_STAT, s);
      if (s[`FST_ST_BUSY] === 1'b0)
        break;
    end
    chk("busy", 8'h00, {7'h0, s[`FST_ST_BUSY]});
  endtask : cmd

  // wait for the window to close, time the frame and the closed spell
  task automatic frame(input int max_low, input bit poke);
    int n;
    n = 0;
    for (int i = 0; i < 2200 && window_open_o !== 1'b0; i++)
      tick();
    per = cyc - t_close;
    t_close = cyc;
    while (window_open_o === 1'b0 && n < 400)
    begin
      // a data write deep in the closed spell must be ignored
      if (poke && n == 16)
      begin
        wr(`FST_A_DATA_A, 8'hEE);
        #1;
        n += 2;
      end
      else
      begin
        tick();
        n++;
      end
    end
    chk("closed", 8'h01, {7'h0, n > 0 && n <= max_low});
  endtask : frame

  initial
  begin
    repeat (16) @(posedge ref_clk_i);
    reset_i <= 1'b0;
    // reset values, unmapped places included
    for (int a = 0; a < 16; a++)
    begin
      rd(a[3:0], rv);
      chk("reset reg", (a == 8) ? 8'h01 : 8'h00, rv);
    end
    // processor channel set-up, update, read-back and cancel
    wr(`FST_A_MDATA, 8'h07);
    wr(`FST_A_MADDR, 8'h04);
    cmd(8'h79);
    chk("code", 8'h09, {4'h0, i_mem.cmc[4]});
    chk("idle", 8'h07, i_mem.cmdat[4]);
    cmd(8'hF0);
    rd_chk("code read", `FST_A_MDATA, 8'h09);
    wr(`FST_A_MDATA, 8'h33);
    cmd(8'h48);
    wr(`FST_A_MDATA, 8'h00);
    cmd(8'hC8);
    rd_chk("data read", `FST_A_MDATA, 8'h33);
    cmd(8'h70);
    cmd(8'hF0);
    rd_chk("cancel", `FST_A_MDATA, 8'h00);
    // channel a, pcm to pcm, top two bits only
    i_mem.dm[5] = 8'h5A;
    i_mem.dm[9] = 8'h00;
    wr(`FST_A_RX_A, 8'h05);
    wr(`FST_A_TX_A, 8'h09);
    wr(`FST_A_DATA_A, 8'hFC);
    wr(`FST_A_CTRL, 8'h47);
    frame(136, 1'b0);
    rd_chk("irq", `FST_A_IRQ, 8'h02);
    rd_chk("data a", `FST_A_DATA_A, 8'h7C);
    chk("tx slot", 8'hC0, i_mem.dm[9]);
    i_mem.dm[9] = 8'h00;
    frame(136, 1'b0);
    chk("period", 8'h01, {7'h0, per == FRAME});
    rd_chk("irq", `FST_A_IRQ, 8'h02);
    chk("resend", 8'h40, i_mem.dm[9]);
    // this frame also pokes the data register while the window is shut
    frame(136, 1'b1);
    rd_chk("irq", `FST_A_IRQ, 8'h03);
    rd_chk("irq clear", `FST_A_IRQ, 8'h00);
    rd_chk("closed write", `FST_A_DATA_A, 8'h7C);
    // both channels, b on configurable slots at full width, a on the low nibble
    i_mem.cmdat[1] = 8'hA5;
    i_mem.cmdat[2] = 8'h00;
    i_mem.cmc[1] = 4'h9;
    i_mem.cmc[2] = 4'h9;
    wr(`FST_A_RX_A + 4'h1, 8'h81);
    wr(`FST_A_TX_A + 4'h1, 8'h82);
    wr(`FST_A_DATA_A + 4'h1, 8'h11);
    wr(`FST_A_CTRL, 8'hCA);
    frame(264, 1'b0);
    rd_chk("data b", `FST_A_DATA_A + 4'h1, 8'hA5);
    chk("cfi tx", 8'h11, i_mem.cmdat[2]);
    chk("sub tx", 8'h4C, i_mem.dm[9]);
    rd_chk("sub rx", `FST_A_DATA_A, 8'h7A);
    // disabled: no closing, no requests, no window-open flag
    wr(`FST_A_CTRL, 8'h00);
    rd(`FST_A_IRQ, rv);
    n0 = n_req;
    s0 = n_shut;
    repeat (2200) tick();
    chk("requests", 8'h00, 8'(n_req - n0));
    chk("shut", 8'h00, 8'(n_shut - s0));
    rd_chk("irq off", `FST_A_IRQ, 8'h00);
    tally_and_finish();
  end
endmodule : frame_sync_transfer_utility_test
